// ### bench/atte_engine_tb.sv
// Self-checking bench for the acquisition trigger timing engine
`timescale 1ns/100ps
module atte_engine_tb;
	logic clk_sys = 1'b0, rst_b = 1'b0;
	logic sw_start = 1'b0, sw_stop = 1'b0, continuous = 1'b0;
	logic start_trig_en = 1'b0, ref_trig_en = 1'b0, hold_trig_en = 1'b0;
	logic hold_active_low = 1'b0, scan_ext_sel = 1'b0, base_ext_sel = 1'b0;
	logic [4:0] start_src = 5'h00, ref_src = 5'h00, hold_src = 5'h0f;
	logic [2:0] start_slot = 3'h0, ref_slot = 3'h0, hold_slot = 3'h0;
	atte_pkg::atte_edge_type start_edge = atte_pkg::ATTE_EDGE_RISE, ref_edge = atte_pkg::ATTE_EDGE_RISE;
	logic [31:0] base_div = 32'h00000002, start_delay = 32'h00000000, sample_count = 32'h00000005;
	logic [15:0] buf_size = 16'h0010, pretrig_count = 16'h0000;
	logic [7:0] pfl_in, pfl_out, pfl_oe_b;
	logic [1:0] ctr_out;
	logic [3:0] int_sig;
	logic [7:0] cmp_event;
	logic ext_scan_clock, ext_scan_clock_base, scan_clock, ref_seen, running, done;
	logic [15:0] wr_addr, ref_addr;
	int error_cnt = 0, checked = 0, cyc = 0;
	int scan_cnt, done_cnt, st_cnt, rf_cnt, sc_out, post;
	// Start sources: index, slot, falling edge, expected to fire
	// Last entry: comparison event set to falling still only starts on rising
	int tsrc[8] = '{0, 1, 8, 10, 14, 3, 22, 16};
	int tslot[8] = '{5, 6, 0, 0, 2, 3, 0, 0};
	bit tfall[8] = '{0, 1, 0, 1, 0, 0, 0, 1};
	bit tfire[8] = '{1, 1, 1, 1, 1, 0, 0, 0};
	////////////////////////////////////////
	atte_far_side far (.clk_sys(clk_sys), .pfl_in(pfl_in), .ctr_out(ctr_out), .int_sig(int_sig),
		.cmp_event(cmp_event), .ext_scan_clock(ext_scan_clock), .ext_scan_clock_base(ext_scan_clock_base));
	atte_engine uut (.clk_sys(clk_sys), .rst_b(rst_b), .pfl_in(pfl_in), .ctr_out(ctr_out),
		.int_sig(int_sig), .cmp_event(cmp_event), .ext_scan_clock(ext_scan_clock),
		.ext_scan_clock_base(ext_scan_clock_base), .sw_start(sw_start), .sw_stop(sw_stop),
		.continuous(continuous), .start_trig_en(start_trig_en), .start_src(start_src),
		.start_slot(start_slot), .start_edge(start_edge), .ref_trig_en(ref_trig_en), .ref_src(ref_src),
		.ref_slot(ref_slot), .ref_edge(ref_edge), .hold_trig_en(hold_trig_en), .hold_src(hold_src),
		.hold_slot(hold_slot), .hold_active_low(hold_active_low), .scan_ext_sel(scan_ext_sel),
		.base_ext_sel(base_ext_sel), .base_div(base_div), .start_delay(start_delay),
		.sample_count(sample_count), .buf_size(buf_size), .pretrig_count(pretrig_count),
		.route_start(8'h02), .route_ref(8'h04), .route_scan(8'h08), .scan_clock(scan_clock),
		.wr_addr(wr_addr), .ref_addr(ref_addr), .ref_seen(ref_seen), .running(running), .done(done),
		.pfl_out(pfl_out), .pfl_oe_b(pfl_oe_b));
	////////////////////////////////////////
	// Free-running system clock
	always #5 clk_sys = ~clk_sys;
	// Tally one-cycle pulses where they stand
	always @(posedge clk_sys) begin
		cyc++;
		scan_cnt += int'(scan_clock === 1'b1);
		done_cnt += int'(done === 1'b1);
		st_cnt += int'(pfl_out[1] === 1'b1);
		rf_cnt += int'(pfl_out[2] === 1'b1);
		sc_out += int'(pfl_out[3] === 1'b1);
		post += int'(scan_clock === 1'b1 && ref_seen === 1'b1);
	end
	////////////////////////////////////////
	task automatic test_done();
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic clr();
		{scan_cnt, done_cnt, st_cnt, rf_cnt, sc_out, post} = '0;
	endtask
	// Extra cycle after the pulse so running has settled
	task automatic go();
		sw_start = 1'b1;
		tick(1);
		sw_start = 1'b0;
		tick(1);
	endtask
	// Bounded wait: engine idle, or scan tally reaching n
	task automatic hold_on(input bit idle, input int n);
		int k;
		for (k = 0; k < 3000; k++) begin
			if (idle ? running === 1'b0 : scan_cnt >= n) break;
			tick(1);
		end
		if (k == 3000) begin
			error_cnt++;
			$display("[FAIL] %0t wait ran out", $time);
			test_done();
		end
		if (idle) tick(2);
	endtask
	task automatic stop();
		sw_stop = 1'b1;
		tick(1);
		sw_stop = 1'b0;
		hold_on(1'b1, 0);
	endtask
	// Early reference is ignored; real one after 12 scans wraps the 8-deep buffer
	task automatic ref_run(input int s, input int sl, input bit fall);
		ref_src = 5'(s);
		ref_slot = 3'(sl);
		ref_edge = fall ? atte_pkg::ATTE_EDGE_FALL : atte_pkg::ATTE_EDGE_RISE;
		far.set_src(s, fall);
		tick(5);
		clr();
		go();
		far.set_src(s, !fall);
		tick(5);
		far.set_src(s, fall);
		tick(5);
		check(ref_seen, 0);
		hold_on(1'b0, 12);
		check(running, 1);
		far.set_src(s, !fall);
		hold_on(1'b1, 0);
		check(post, 5);
		check(scan_cnt, 17);
		check(ref_addr, 4);
		check(wr_addr, 1);
		check(rf_cnt, 1);
		check(ref_seen, 1);
		far.set_src(s, 1'b0);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		int i, t0;
		tick(16);
		check(running, 0);
		check(pfl_oe_b, 8'hff);
		rst_b = 1'b1;
		tick(2);
		check(pfl_oe_b, 8'hf1);
		// Software start, finite count; second start while running ignored
		clr();
		go();
		go();
		hold_on(1'b1, 0);
		check(scan_cnt, 5);
		check(wr_addr, 5);
		check(st_cnt, 1);
		check(sc_out, 5);
		check(done_cnt, 1);
		// Start trigger over every kind of source, legal and refused
		start_trig_en = 1'b1;
		sample_count = 32'h00000003;
		for (i = 0; i < 8; i++) begin
			start_src = 5'(tsrc[i]);
			start_slot = 3'(tslot[i]);
			start_edge = tfall[i] ? atte_pkg::ATTE_EDGE_FALL : atte_pkg::ATTE_EDGE_RISE;
			far.set_src(tsrc[i], tfall[i]);
			tick(5);
			clr();
			go();
			tick(20);
			check(scan_cnt, 0);
			far.set_src(tsrc[i], !tfall[i]);
			if (tfire[i]) begin
				hold_on(1'b1, 0);
				check(scan_cnt, 3);
				check(st_cnt, 1);
			end else begin
				tick(30);
				check(scan_cnt, 0);
				stop();
			end
			far.set_src(tsrc[i], 1'b0);
		end
		// Programmed delay before the first internal scan
		start_trig_en = 1'b0;
		start_delay = 32'h0000001e;
		base_div = 32'h00000001;
		clr();
		t0 = cyc;
		go();
		hold_on(1'b0, 1);
		check(cyc - t0 >= 33 && cyc - t0 <= 37, 1);
		hold_on(1'b1, 0);
		start_delay = 32'h00000000;
		// Reference stop, rising line then falling comparison event
		ref_trig_en = 1'b1;
		buf_size = 16'h0008;
		pretrig_count = 16'h0003;
		base_div = 32'h00000014;
		ref_run(2, 6, 1'b0);
		ref_run(15, 0, 1'b1);
		ref_trig_en = 1'b0;
		// Hold level in both polarities, continuous mode
		hold_trig_en = 1'b1;
		continuous = 1'b1;
		base_div = 32'h00000002;
		for (i = 0; i < 2; i++) begin
			hold_active_low = i[0];
			far.set_src(15, !i[0]);
			tick(5);
			clr();
			go();
			tick(40);
			check(scan_cnt, 0);
			far.set_src(15, i[0]);
			tick(40);
			check(scan_cnt > 10, 1);
			check(running, 1);
			stop();
			check(done_cnt, 1);
		end
		far.set_src(15, 1'b0);
		hold_trig_en = 1'b0;
		continuous = 1'b0;
		// External scan clock: one sample per rising edge
		scan_ext_sel = 1'b1;
		sample_count = 32'h00000004;
		clr();
		go();
		far.burst(4, 1'b0);
		hold_on(1'b1, 0);
		check(scan_cnt, 4);
		// External base divided by three
		scan_ext_sel = 1'b0;
		base_ext_sel = 1'b1;
		base_div = 32'h00000003;
		sample_count = 32'h00000003;
		clr();
		go();
		far.burst(9, 1'b1);
		hold_on(1'b1, 0);
		check(scan_cnt, 3);
		check(pfl_oe_b, 8'hf1);
		test_done();
	end
endmodule // atte_engine_tb

// ### bench/atte_far_side.sv
// Far-side model: module trigger sources and external clocks
`timescale 1ns/100ps
module atte_far_side (
	input wire logic clk_sys,
	output logic [atte_pkg::NUM_PFL-1:0] pfl_in,
	output logic [atte_pkg::NUM_CTR-1:0] ctr_out,
	output logic [atte_pkg::NUM_INT-1:0] int_sig,
	output logic [atte_pkg::NUM_MOD-1:0] cmp_event,
	output logic ext_scan_clock,
	output logic ext_scan_clock_base
);
	logic [21:0] src = 22'h000000;
	logic [1:0] ext = 2'h0;
	////////////////////////////////////////
	// Sources laid out in the engine's index order
	assign {cmp_event, int_sig, ctr_out, pfl_in} = src;
	// External clocks stand still outside bursts
	assign {ext_scan_clock_base, ext_scan_clock} = ext;
	////////////////////////////////////////
	// Change a source just after an edge; out-of-map index drives nothing
	task automatic set_src(input int i, input logic v);
		@(posedge clk_sys);
		#1;
		if (i < 22) src[i] = v;
	endtask
	// Slow edges, three cycles per level, so the synchroniser sees each
	task automatic burst(input int n, input logic base);
		repeat (n) begin
			repeat (3) @(posedge clk_sys);
			#1;
			ext[base] = 1'b1;
			repeat (3) @(posedge clk_sys);
			#1;
			ext[base] = 1'b0;
		end
	endtask
endmodule // atte_far_side

// ### common/atte_pkg.sv
// Package of constants and types for the acquisition trigger timing engine
package atte_pkg;
	localparam int NUM_PFL = 8;
	localparam int NUM_CTR = 2;
	localparam int NUM_INT = 4;
	localparam int NUM_MOD = 8;
	localparam int NUM_SRC = 24;
	localparam int SRC_W = 5;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 16;
	localparam int SLOT_W = 3;
	// Source map: lines, counters, internals, module comparison events
	localparam logic [SRC_W-1:0] SRC_PFL_BASE = 5'h00;
	localparam logic [SRC_W-1:0] SRC_CTR_BASE = 5'h08;
	localparam logic [SRC_W-1:0] SRC_INT_BASE = 5'h0a;
	localparam logic [SRC_W-1:0] SRC_CMP_BASE = 5'h0e;
	localparam logic [SRC_W-1:0] SRC_END = 5'h16;
	// Digital lines only live on correlated modules in these two slots
	localparam logic [SLOT_W-1:0] DIG_SLOT_A = 3'h5;
	localparam logic [SLOT_W-1:0] DIG_SLOT_B = 3'h6;
	localparam logic [CNT_W-1:0] ONE = 32'h00000001;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
	typedef enum logic [1:0] {
		ATTE_EDGE_RISE,
		ATTE_EDGE_FALL
	} atte_edge_type;
	typedef enum {
		ATTE_IDLE,
		ATTE_ARMED,
		ATTE_DELAY,
		ATTE_RUN,
		ATTE_POST
	} atte_state_type;
endpackage

// ### design/atte_engine.sv
// Analog-input acquisition timing and trigger engine, single instance per chassis
// What this block does
// [RL1] One timing engine; one input task runs
// [RL2] One scan clock serves channels of all modules
// [RL3] Start, reference and hold triggers, separate sources
// [RL4] Digital lines only from slots five, six
// [RL5] No start trigger: software start begins
// [RL6] Finite ends by count/reference; continuous by software
// [RL7] Posttriggered: no samples before start trigger
// [RL8] Programmable delay from start to first scan; skipped when the external scan clock is selected
// [RL9] Start on chosen edge of selected source
// [RL10] Comparison event start on rising edge
// [RL11] Start trigger out as active-high pulse
// [RL12] Posttrigger count equals buffer minus pretrigger
// [RL13] Reference ignored until pretrigger samples stored
// [RL14] Full buffer overwrites oldest sample
// [RL15] After reference, store posttrigger count, then end
// [RL16] Reference stops on chosen edge of source
// [RL17] Comparison reference on chosen edge
// [RL18] Reference trigger routable to output lines
// [RL19] Hold is level only, polarity programmable
// [RL20] Comparison hold stops scan while low/high; has no effect when the external scan clock is selected
// [RL21] Each scan pulse starts one full sample
// [RL22] Scan clock divides base; base never output
// [RL23] Inputs synchronised, one event per edge
`timescale 1ns/100ps
module atte_engine (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [atte_pkg::NUM_PFL-1:0] pfl_in,
	input wire logic [atte_pkg::NUM_CTR-1:0] ctr_out,
	input wire logic [atte_pkg::NUM_INT-1:0] int_sig,
	input wire logic [atte_pkg::NUM_MOD-1:0] cmp_event,
	input wire logic ext_scan_clock,
	input wire logic ext_scan_clock_base,
	input wire logic sw_start,
	input wire logic sw_stop,
	input wire logic continuous,
	input wire logic start_trig_en,
	input wire logic [atte_pkg::SRC_W-1:0] start_src,
	input wire logic [atte_pkg::SLOT_W-1:0] start_slot,
	input wire atte_pkg::atte_edge_type start_edge,
	input wire logic ref_trig_en,
	input wire logic [atte_pkg::SRC_W-1:0] ref_src,
	input wire logic [atte_pkg::SLOT_W-1:0] ref_slot,
	input wire atte_pkg::atte_edge_type ref_edge,
	input wire logic hold_trig_en,
	input wire logic [atte_pkg::SRC_W-1:0] hold_src,
	input wire logic [atte_pkg::SLOT_W-1:0] hold_slot,
	input wire logic hold_active_low,
	input wire logic scan_ext_sel,
	input wire logic base_ext_sel,
	input wire logic [atte_pkg::CNT_W-1:0] base_div,
	input wire logic [atte_pkg::CNT_W-1:0] start_delay,
	input wire logic [atte_pkg::CNT_W-1:0] sample_count,
	input wire logic [atte_pkg::ADDR_W-1:0] buf_size,
	input wire logic [atte_pkg::ADDR_W-1:0] pretrig_count,
	input wire logic [atte_pkg::NUM_PFL-1:0] route_start,
	input wire logic [atte_pkg::NUM_PFL-1:0] route_ref,
	input wire logic [atte_pkg::NUM_PFL-1:0] route_scan,
	output logic scan_clock,
	output logic [atte_pkg::ADDR_W-1:0] wr_addr,
	output logic [atte_pkg::ADDR_W-1:0] ref_addr,
	output logic ref_seen,
	output logic running,
	output logic done,
	output logic [atte_pkg::NUM_PFL-1:0] pfl_out,
	output logic [atte_pkg::NUM_PFL-1:0] pfl_oe_b
);
	typedef struct packed {
		atte_pkg::atte_state_type state;
		logic [1:0] xs1;
		logic [1:0] xs2;
		logic [1:0] xs3;
		logic [atte_pkg::CNT_W-1:0] div_cnt;
		logic [atte_pkg::CNT_W-1:0] dly_cnt;
		logic [atte_pkg::CNT_W-1:0] smp_cnt;
		logic [atte_pkg::ADDR_W-1:0] stored;
		logic [atte_pkg::ADDR_W-1:0] post_cnt;
		logic [atte_pkg::ADDR_W-1:0] waddr;
		logic [atte_pkg::ADDR_W-1:0] raddr;
		logic rseen;
		logic scan;
		logic start_p;
		logic ref_p;
		logic fin;
		logic run;
		logic [atte_pkg::NUM_PFL-1:0] pout;
		logic [atte_pkg::NUM_PFL-1:0] poe_b;
	} atte_st_type;

	atte_st_type st;
	atte_st_type next_st;
	logic [atte_pkg::NUM_SRC-1:0] srcs;
	logic start_lvl;
	logic start_rise;
	logic start_fall_lvl;
	logic start_fall;
	logic ref_lvl;
	logic ref_edge_p;
	logic hold_lvl;
	logic base_tick;
	logic ext_scan_tick;
	logic scan_tick;
	logic start_evt;
	logic is_cmp_start;

	// Circular buffer address advance
	function automatic logic [atte_pkg::ADDR_W-1:0] wrap_inc(input logic [atte_pkg::ADDR_W-1:0] a,
		input logic [atte_pkg::ADDR_W-1:0] size);
		logic [atte_pkg::ADDR_W-1:0] n;
		n = a + atte_pkg::ADDR_ONE;
		if (n >= size) begin
			n = '0;
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Source bus and trigger selectors
	// Two spare indices above the map read as low
	assign srcs = {2'b00, cmp_event, int_sig, ctr_out, pfl_in};
	assign is_cmp_start = start_src >= atte_pkg::SRC_CMP_BASE;

	// Start selector: comparison events always use the rising edge
	atte_trig_sel u_start (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.src_async(srcs),
		.sel(start_src),
		.slot(start_slot),
		.invert(1'b0),
		.level(start_lvl),
		.edge_pulse(start_rise)
	);

	atte_trig_sel u_start_f (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.src_async(srcs),
		.sel(start_src),
		.slot(start_slot),
		.invert(1'b1),
		.level(start_fall_lvl),
		.edge_pulse(start_fall)
	);

	atte_trig_sel u_ref (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.src_async(srcs),
		.sel(ref_src), // RL3
		.slot(ref_slot),
		.invert(ref_edge == atte_pkg::ATTE_EDGE_FALL), // RL16 RL17
		.level(ref_lvl),
		.edge_pulse(ref_edge_p)
	);

	atte_trig_sel u_hold (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.src_async(srcs),
		.sel(hold_src), // RL3
		.slot(hold_slot),
		.invert(hold_active_low), // RL19 RL20
		.level(hold_lvl),
		.edge_pulse()
	);

	// Edge choice for the start trigger
	assign start_evt = (is_cmp_start || start_edge == atte_pkg::ATTE_EDGE_RISE) ? start_rise : start_fall; // RL9 RL10

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_st = st;
		// External clocks pass three flops, edge taken from the second and third
		next_st.xs1 = {ext_scan_clock, ext_scan_clock_base};
		next_st.xs2 = st.xs1;
		next_st.xs3 = st.xs2; // RL23
		next_st.scan = 1'b0;
		next_st.start_p = 1'b0;
		next_st.ref_p = 1'b0;
		next_st.fin = 1'b0;
		base_tick = base_ext_sel ? (st.xs2[0] & ~st.xs3[0]) : 1'b1;
		ext_scan_tick = st.xs2[1] & ~st.xs3[1];
		scan_tick = 1'b0;

		// Scan clock from base divider; hold freezes only the internal clock
		if (st.state == atte_pkg::ATTE_RUN || st.state == atte_pkg::ATTE_POST) begin
			if (scan_ext_sel) begin
				scan_tick = ext_scan_tick;
			end else if (base_tick && !(hold_trig_en && hold_lvl)) begin // RL19 RL20
				if (st.div_cnt + atte_pkg::ONE >= base_div) begin // RL22
					next_st.div_cnt = '0;
					scan_tick = 1'b1;
				end else begin
					next_st.div_cnt = st.div_cnt + atte_pkg::ONE;
				end
			end
		end

		unique case (st.state)
			atte_pkg::ATTE_IDLE: begin
				// Single engine: a new start is taken only from idle
				if (sw_start) begin // RL1
					next_st.waddr = '0;
					next_st.stored = '0;
					next_st.smp_cnt = '0;
					next_st.post_cnt = '0;
					next_st.rseen = 1'b0;
					next_st.div_cnt = '0;
					next_st.state = start_trig_en ? atte_pkg::ATTE_ARMED : atte_pkg::ATTE_DELAY; // RL5
					next_st.dly_cnt = '0;
					next_st.start_p = ~start_trig_en;
				end
			end
			atte_pkg::ATTE_ARMED: begin
				// No scans before the start trigger
				if (sw_stop) begin
					next_st.state = atte_pkg::ATTE_IDLE;
				end else if (start_evt) begin // RL7
					next_st.start_p = 1'b1; // RL11
					next_st.state = atte_pkg::ATTE_DELAY;
				end
			end
			atte_pkg::ATTE_DELAY: begin
				// Programmed delay before first internal scan
				if (sw_stop) begin
					next_st.state = atte_pkg::ATTE_IDLE;
				end else if (scan_ext_sel || st.dly_cnt >= start_delay) begin // RL8
					next_st.state = atte_pkg::ATTE_RUN;
					next_st.div_cnt = base_div;
				end else begin
					next_st.dly_cnt = st.dly_cnt + atte_pkg::ONE;
				end
			end
			atte_pkg::ATTE_RUN, atte_pkg::ATTE_POST: begin
				if (scan_tick) begin
					next_st.scan = 1'b1; // RL21 RL2
					next_st.waddr = wrap_inc(st.waddr, buf_size); // RL14
					next_st.smp_cnt = st.smp_cnt + atte_pkg::ONE;
					if (st.stored < buf_size) begin
						next_st.stored = st.stored + atte_pkg::ADDR_ONE;
					end
					if (st.state == atte_pkg::ATTE_POST) begin
						next_st.post_cnt = st.post_cnt + atte_pkg::ADDR_ONE;
					end
				end
				// Reference looked at only once pretrigger samples are in
				if (st.state == atte_pkg::ATTE_RUN && ref_trig_en && !continuous && ref_edge_p
					&& st.stored >= pretrig_count) begin // RL13
					next_st.state = atte_pkg::ATTE_POST;
					next_st.rseen = 1'b1;
					next_st.raddr = st.waddr;
					next_st.ref_p = 1'b1; // RL18
				end
				// End conditions by mode
				if (sw_stop && continuous) begin // RL6
					next_st.fin = 1'b1;
				end else if (!continuous && !ref_trig_en && scan_tick
					&& st.smp_cnt + atte_pkg::ONE >= sample_count) begin // RL6
					next_st.fin = 1'b1;
				end else if (st.state == atte_pkg::ATTE_POST && scan_tick
					&& st.post_cnt + atte_pkg::ADDR_ONE >= buf_size - pretrig_count) begin // RL12 RL15
					next_st.fin = 1'b1;
				end
				if (next_st.fin) begin
					next_st.state = atte_pkg::ATTE_IDLE;
				end
			end
		endcase

		// Busy flag registered so the pin comes straight from a flop
		next_st.run = (next_st.state != atte_pkg::ATTE_IDLE); // RL1

		// Output routing; the base clock is deliberately never routable
		for (int i = 0; i < atte_pkg::NUM_PFL; i++) begin
			next_st.pout[i] = (route_start[i] & next_st.start_p) | (route_ref[i] & next_st.ref_p)
				| (route_scan[i] & next_st.scan); // RL11 RL18 RL21 RL22
			next_st.poe_b[i] = ~(route_start[i] | route_ref[i] | route_scan[i]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st <= '0;
			st.poe_b <= '1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops
	assign scan_clock = st.scan;
	assign wr_addr = st.waddr;
	assign ref_addr = st.raddr;
	assign ref_seen = st.rseen;
	assign running = st.run;
	assign done = st.fin;
	assign pfl_out = st.pout;
	assign pfl_oe_b = st.poe_b;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_no_early_scan;
		@(posedge clk_sys) disable iff (!rst_b) st.state == atte_pkg::ATTE_ARMED |=> !scan_clock;
	endproperty
	a_no_early_scan: assert property (p_no_early_scan) else $error("scan before start trigger"); // RL7

	property p_hold_stops;
		@(posedge clk_sys) disable iff (!rst_b)
			(hold_trig_en && hold_lvl && !scan_ext_sel && $stable(hold_lvl)) |=> !scan_clock;
	endproperty
	a_hold_stops: assert property (p_hold_stops) else $error("scan during hold"); // RL19

	property p_ref_after_pre;
		@(posedge clk_sys) disable iff (!rst_b) $rose(ref_seen) |-> $past(st.stored) >= pretrig_count;
	endproperty
	a_ref_after_pre: assert property (p_ref_after_pre) else $error("reference taken too early"); // RL13

	property p_cont_no_end;
		@(posedge clk_sys) disable iff (!rst_b) (continuous && running && !sw_stop) |=> !done;
	endproperty
	a_cont_no_end: assert property (p_cont_no_end) else $error("continuous ended without stop"); // RL6

	property p_swstart;
		@(posedge clk_sys) disable iff (!rst_b)
			(st.state == atte_pkg::ATTE_IDLE && sw_start && !start_trig_en) |=> st.state == atte_pkg::ATTE_DELAY;
	endproperty
	a_swstart: assert property (p_swstart) else $error("software start ignored"); // RL5

	property p_start_out;
		@(posedge clk_sys) disable iff (!rst_b)
			(st.state == atte_pkg::ATTE_ARMED && start_evt && !sw_stop && route_start != '0)
			|=> (pfl_out & $past(route_start)) == $past(route_start);
	endproperty
	a_start_out: assert property (p_start_out) else $error("start trigger not routed"); // RL11

	property p_wrap;
		@(posedge clk_sys) disable iff (!rst_b) running && buf_size != '0 |-> wr_addr < buf_size;
	endproperty
	a_wrap: assert property (p_wrap) else $error("buffer address past end"); // RL14

	property p_single;
		@(posedge clk_sys) disable iff (!rst_b) (running && sw_start && !done) |=> running;
	endproperty
	a_single: assert property (p_single) else $error("second start disturbed task"); // RL1
endmodule // atte_engine

// ### design/atte_trig_sel.sv
// Trigger source selector with two-stage synchroniser and edge detect
`timescale 1ns/100ps
module atte_trig_sel (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [atte_pkg::NUM_SRC-1:0] src_async,
	input wire logic [atte_pkg::SRC_W-1:0] sel,
	input wire logic [atte_pkg::SLOT_W-1:0] slot,
	input wire logic invert,
	output logic level,
	output logic edge_pulse
);
	typedef struct packed {
		logic [atte_pkg::NUM_SRC-1:0] sync1;
		logic [atte_pkg::NUM_SRC-1:0] sync2;
		logic lvl;
		logic lvl_d;
	} atte_sel_st_type;

	atte_sel_st_type st;
	atte_sel_st_type next_st;
	logic allowed;

	// Digital lines accepted only from slots five and six
	always_comb begin
		allowed = 1'b1;
		if (sel < atte_pkg::SRC_CTR_BASE) begin
			allowed = (slot == atte_pkg::DIG_SLOT_A) || (slot == atte_pkg::DIG_SLOT_B); // RL4
		end
		if (sel >= atte_pkg::SRC_END) begin
			allowed = 1'b0;
		end
	end

	// Synchronise all sources before any logic looks at them
	always_comb begin
		next_st = st;
		next_st.sync1 = src_async;
		next_st.sync2 = st.sync1; // RL23
		next_st.lvl = allowed & (st.sync2[sel] ^ invert);
		next_st.lvl_d = st.lvl;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.lvl;
	assign edge_pulse = st.lvl & ~st.lvl_d; // RL23

	property p_one_pulse;
		@(posedge clk_sys) disable iff (!rst_b) edge_pulse |=> !edge_pulse;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("edge pulse lasted two cycles"); // RL23
endmodule // atte_trig_sel
